// File: rtl/rtp_pkg.sv
// Shared constants and types for the real-time counter tail and periodic tick timer
package rtp_pkg;

	// Register indices; byte address on the bus is four times the index
	localparam logic [5:0] IDX_COUNTER_CTRL   = 6'h00;
	localparam logic [5:0] IDX_SYNC_STATUS    = 6'h01;
	localparam logic [5:0] IDX_COUNTER_FLAGS  = 6'h03;
	localparam logic [5:0] IDX_BYTE_LATCH     = 6'h04;
	localparam logic [5:0] IDX_HALT_BEHAVIOR  = 6'h05;
	localparam logic [5:0] IDX_DRIFT_TRIM     = 6'h06;
	localparam logic [5:0] IDX_SOURCE_CHOICE  = 6'h07;
	localparam logic [5:0] IDX_COUNT_VALUE    = 6'h08;
	localparam logic [5:0] IDX_WRAP_LIMIT     = 6'h0a;
	localparam logic [5:0] IDX_MATCH_VALUE    = 6'h0c;
	localparam logic [5:0] IDX_TICK_SETUP     = 6'h10;
	localparam logic [5:0] IDX_TICK_SYNC      = 6'h11;
	localparam logic [5:0] IDX_TICK_IRQ_EN    = 6'h12;
	localparam logic [5:0] IDX_TICK_IRQ_PEND  = 6'h13;
	localparam logic [5:0] IDX_TICK_HALT      = 6'h15;
	localparam logic [5:0] HIGH_BYTE_STEP     = 6'h01;

	// Field positions
	localparam int BIT_COUNTER_ON    = 0;
	localparam int BIT_DRIFT_TRIM_ON = 2;
	localparam int POS_PRESCALE      = 3;
	localparam int BIT_RUN_HALTED    = 0;
	localparam int BIT_TRIM_SIGN     = 7;
	localparam int BIT_TICK_RUN      = 0;
	localparam int POS_TICK_PERIOD   = 3;
	localparam int BIT_WRAP_FLAG     = 0;
	localparam int BIT_MATCH_FLAG    = 1;
	localparam int BIT_COUNT_SYNC    = 1;
	localparam int BIT_LIMIT_SYNC    = 2;
	localparam int BIT_TICK_SYNCING  = 0;
	localparam int BIT_TICK_IRQ      = 0;

	// Reset values
	localparam logic [15:0] COUNT_RESET = 16'h0000;
	localparam logic [15:0] LIMIT_RESET = 16'hffff;
	localparam logic [15:0] MATCH_RESET = 16'h0000;
	localparam logic [7:0]  BYTE_RESET  = 8'h00;

	// Clock source encodings
	localparam logic [1:0] SRC_INTERNAL_32K = 2'h0;
	localparam logic [1:0] SRC_INTERNAL_1K  = 2'h1;
	localparam logic [1:0] SRC_CRYSTAL_32K  = 2'h2;
	localparam logic [1:0] SRC_PIN_FED      = 2'h3;

	// Tick period codes
	localparam logic [3:0] TICK_PERIOD_OFF = 4'h0;
	localparam logic [3:0] TICK_PERIOD_RSV = 4'hf;

	// Slow-clock edges before a written value takes effect
	localparam logic [1:0] SYNC_SLOW_EDGES = 2'h2;
	// Slow-clock cycles in one drift-correction interval
	localparam int PPM_INTERVAL = 1000000;

	typedef struct packed {
		logic        counter_on;
		logic        drift_trim_on;
		logic [3:0]  prescale;
		logic        run_while_halted;
		logic [7:0]  drift_trim;
		logic [1:0]  source_choice;
		logic [15:0] wrap_limit;
		logic [15:0] match_value;
		logic        tick_irq_en;
		logic        tick_run_while_halted;
		logic [7:0]  byte_latch;
		logic [7:0]  tick_setup;
	} rtp_regs_t;

	typedef struct packed {
		logic        wrap_flag;
		logic        match_flag;
		logic        tick_irq;
	} rtp_flags_t;

endpackage

// File: rtl/rtp_core.sv
// Real-time counter tail registers, drift trim and periodic tick timer
//
// Notes on behaviour
// - Run-while-halted bit 0 freezes counter or tick timer during debug halt.
// - Trim sign 0 removes prescaler clocks so counting slows.
// - Trim sign 1 adds prescaler clocks; software keeps prescale at two or more.
// - Seven-bit trim magnitude is clocks corrected per million slow cycles.
// - Source choice picks internal 32k, 1k tap, crystal 32k or pin clock.
// - Count value is low byte at base, high byte next; resets zero.
// - Count and limit writes take effect after two slow-clock edges.
// - Wrap limit is low and high byte pair, resets all ones.
// - Match value is low and high byte pair, resets zero.
// - Tick period code 1..14 gives 4 doubling to 32768; 0 off, 15 reserved.
// - Tick setup bit 0 enables the periodic tick timer.
// - Tick sync bit reads one while tick setup is being carried over.
// - Tick interrupt enable gates the periodic request.
// - Tick flag sets on each periodic event; writing one clears it.
// - One shared byte latch serves all 16-bit registers.
// - Drift trim applies only while drift trim on is set.
// - Count reaching limit wraps to zero and sets wrap flag; write one clears.
// - Count equal to match sets match flag; write one clears.
`timescale 1ns/1ps
`default_nettype none

module rtp_core #(
	parameter int PPM_CYCLES = rtp_pkg::PPM_INTERVAL
) (
	input  wire logic        clk_in,
	input  wire logic        resetn_in,
	input  wire logic [7:0]  avs_address_in,
	input  wire logic        avs_read_in,
	input  wire logic        avs_write_in,
	input  wire logic [31:0] avs_writedata_in,
	input  wire logic [3:0]  avs_byteenable_in,
	output logic      [31:0] avs_readdata_out,
	output logic             avs_waitrequest_out,
	input  wire logic [3:0]  slow_src_in,
	input  wire logic        cpu_halted_in,
	output logic             tick_irq_out,
	output logic             wrap_flag_out,
	output logic             match_flag_out
);

	rtp_pkg::rtp_regs_t  regs;
	rtp_pkg::rtp_regs_t  next_regs;
	rtp_pkg::rtp_flags_t flags;
	rtp_pkg::rtp_flags_t next_flags;

	logic [31:0] next_readdata;
	logic        next_waitrequest;
	logic        next_tick_irq_out;

	logic [15:0] count_value;
	logic [15:0] next_count_value;
	logic [15:0] presc_cnt;
	logic [15:0] next_presc_cnt;
	logic [19:0] trim_acc;
	logic [19:0] next_trim_acc;
	logic [19:0] ppm_cnt;
	logic [19:0] next_ppm_cnt;

	logic [1:0]  count_sync;
	logic [1:0]  next_count_sync;
	logic [15:0] count_pend;
	logic [15:0] next_count_pend;
	logic [1:0]  limit_sync;
	logic [1:0]  next_limit_sync;
	logic [15:0] limit_pend;
	logic [15:0] next_limit_pend;
	logic [15:0] limit_active;
	logic [15:0] next_limit_active;

	logic [1:0]  tick_sync;
	logic [1:0]  next_tick_sync;
	logic        tick_run;
	logic        next_tick_run;
	logic [3:0]  tick_period;
	logic [3:0]  next_tick_period;
	logic [15:0] tick_cnt;
	logic [15:0] next_tick_cnt;

	logic [3:0]  src_meta;
	logic [3:0]  src_sync;
	logic [3:0]  src_prev;

	// Prescaler wrap mask for a divide-by-two-to-the-n setting
	function automatic logic [15:0] div_mask(input logic [3:0] n);
		div_mask = (16'h0001 << n) - 16'h0001;
	endfunction

	// Last tick-counter value for a period code
	function automatic logic [15:0] tick_last(input logic [3:0] code);
		tick_last = (16'h0001 << (code + 4'h1)) - 16'h0001;
	endfunction

	always_comb begin
		logic [5:0]  idx;
		logic [5:0]  pair_base;
		logic        is_high;
		logic        is_pair;
		logic [15:0] pair_val;
		logic [7:0]  rd_byte;
		logic [7:0]  wd;
		logic        do_read;
		logic        do_write;
		logic        slow_tick;
		logic        cnt_frozen;
		logic        tick_frozen;
		logic        corr;
		logic [16:0] step;
		logic [16:0] presc_sum;
		logic [15:0] mask;
		logic        cnt_tick;
		logic        set_wrap;
		logic        set_match;
		logic        set_tick;
		logic [19:0] acc_sum;

		idx = avs_address_in[7:2];
		pair_base = {idx[5:1], 1'b0};
		is_high = idx[0];
		is_pair = (pair_base == rtp_pkg::IDX_COUNT_VALUE)
			|| (pair_base == rtp_pkg::IDX_WRAP_LIMIT)
			|| (pair_base == rtp_pkg::IDX_MATCH_VALUE);
		wd = avs_writedata_in[7:0];
		do_read = avs_read_in && avs_waitrequest_out;
		do_write = avs_write_in && !avs_waitrequest_out && avs_byteenable_in[0]
			&& (avs_address_in[1:0] == 2'h0);

		next_regs = regs;
		next_flags = flags;
		next_count_value = count_value;
		next_presc_cnt = presc_cnt;
		next_trim_acc = trim_acc;
		next_ppm_cnt = ppm_cnt;
		next_count_sync = count_sync;
		next_count_pend = count_pend;
		next_limit_sync = limit_sync;
		next_limit_pend = limit_pend;
		next_limit_active = limit_active;
		next_tick_sync = tick_sync;
		next_tick_run = tick_run;
		next_tick_period = tick_period;
		next_tick_cnt = tick_cnt;

		// One wait cycle, then answer
		next_waitrequest = !((avs_read_in || avs_write_in) && avs_waitrequest_out);
		next_readdata = avs_readdata_out;

		unique case (pair_base)
			rtp_pkg::IDX_COUNT_VALUE: pair_val = count_value;
			rtp_pkg::IDX_WRAP_LIMIT:  pair_val = regs.wrap_limit;
			default:                  pair_val = regs.match_value;
		endcase

		// Register read
		rd_byte = 8'h00;
		if (is_pair) begin
			rd_byte = is_high ? regs.byte_latch : pair_val[7:0];
		end else begin
			unique case (idx)
				rtp_pkg::IDX_COUNTER_CTRL:
					rd_byte = {1'b0, regs.prescale, regs.drift_trim_on, 1'b0, regs.counter_on};
				rtp_pkg::IDX_SYNC_STATUS:
					rd_byte = {5'h00, (limit_sync != 2'h0), (count_sync != 2'h0), 1'b0};
				rtp_pkg::IDX_COUNTER_FLAGS:
					rd_byte = {6'h00, flags.match_flag, flags.wrap_flag};
				rtp_pkg::IDX_BYTE_LATCH:    rd_byte = regs.byte_latch;
				rtp_pkg::IDX_HALT_BEHAVIOR: rd_byte = {7'h00, regs.run_while_halted};
				rtp_pkg::IDX_DRIFT_TRIM:    rd_byte = regs.drift_trim;
				rtp_pkg::IDX_SOURCE_CHOICE: rd_byte = {6'h00, regs.source_choice};
				rtp_pkg::IDX_TICK_SETUP:    rd_byte = {1'b0, regs.tick_setup[6:3], 2'h0,
					regs.tick_setup[0]};
				rtp_pkg::IDX_TICK_SYNC:     rd_byte = {7'h00, (tick_sync != 2'h0)};
				rtp_pkg::IDX_TICK_IRQ_EN:   rd_byte = {7'h00, regs.tick_irq_en};
				rtp_pkg::IDX_TICK_IRQ_PEND: rd_byte = {7'h00, flags.tick_irq};
				rtp_pkg::IDX_TICK_HALT:     rd_byte = {7'h00, regs.tick_run_while_halted};
				default:                    rd_byte = 8'h00;
			endcase
		end
		if (do_read) begin
			next_readdata = {24'h000000, (avs_address_in[1:0] == 2'h0) ? rd_byte : 8'h00};
			// Low byte read parks the high byte so the pair reads coherently
			if (is_pair && !is_high && (avs_address_in[1:0] == 2'h0)) begin
				next_regs.byte_latch = pair_val[15:8];
			end
		end

		// Slow clock: pick a source, take its rising edge
		slow_tick = src_sync[regs.source_choice] && !src_prev[regs.source_choice];
		cnt_frozen = cpu_halted_in && !regs.run_while_halted;
		tick_frozen = cpu_halted_in && !regs.tick_run_while_halted;

		// Drift trim spread evenly over each million slow cycles
		acc_sum = trim_acc + {13'h0000, regs.drift_trim[6:0]};
		corr = 1'b0;
		cnt_tick = 1'b0;
		set_wrap = 1'b0;
		set_match = 1'b0;
		set_tick = 1'b0;
		step = 17'h00001;
		mask = div_mask(regs.prescale);
		if (slow_tick && regs.counter_on && !cnt_frozen) begin
			if (regs.drift_trim_on) begin
				next_ppm_cnt = ppm_cnt + 20'h00001;
				next_trim_acc = acc_sum;
				if (acc_sum >= 20'(PPM_CYCLES)) begin
					corr = 1'b1;
					next_trim_acc = 20'(acc_sum - 20'(PPM_CYCLES));
				end
				// Last edge of the interval still adds, so no correction step is lost
				if (ppm_cnt == 20'(PPM_CYCLES - 1)) begin
					next_ppm_cnt = 20'h00000;
					next_trim_acc = 20'h00000;
				end
			end
			if (corr) begin
				// Positive skips a prescaler clock, negative adds one
				step = regs.drift_trim[rtp_pkg::BIT_TRIM_SIGN] ? 17'h00002 : 17'h00000;
			end
			presc_sum = {1'b0, presc_cnt} + step;
			if (presc_sum > {1'b0, mask}) begin
				cnt_tick = 1'b1;
				next_presc_cnt = 16'(presc_sum - {1'b0, mask} - 17'h00001);
			end else begin
				next_presc_cnt = presc_sum[15:0];
			end
		end

		if (cnt_tick) begin
			if (count_value == regs.match_value) begin
				set_match = 1'b1;
			end
			if (count_value == limit_active) begin
				next_count_value = 16'h0000;
				set_wrap = 1'b1;
			end else begin
				next_count_value = count_value + 16'h0001;
			end
		end

		// Hand-over of written values, two slow edges late
		if (slow_tick) begin
			if (count_sync != 2'h0) begin
				next_count_sync = count_sync - 2'h1;
				if (count_sync == 2'h1) begin
					next_count_value = count_pend;
				end
			end
			if (limit_sync != 2'h0) begin
				next_limit_sync = limit_sync - 2'h1;
				if (limit_sync == 2'h1) begin
					next_limit_active = limit_pend;
				end
			end
			if (tick_sync != 2'h0) begin
				next_tick_sync = tick_sync - 2'h1;
				if (tick_sync == 2'h1) begin
					next_tick_run = regs.tick_setup[rtp_pkg::BIT_TICK_RUN];
					next_tick_period = regs.tick_setup[6:3];
					next_tick_cnt = 16'h0000;
				end
			end
		end

		// Periodic tick timer
		if (slow_tick && tick_run && !tick_frozen && (tick_sync == 2'h0)
				&& (tick_period != rtp_pkg::TICK_PERIOD_OFF)
				&& (tick_period != rtp_pkg::TICK_PERIOD_RSV)) begin
			if (tick_cnt >= tick_last(tick_period)) begin
				next_tick_cnt = 16'h0000;
				set_tick = 1'b1;
			end else begin
				next_tick_cnt = tick_cnt + 16'h0001;
			end
		end

		// Register write; hardware set wins over a one-to-clear
		if (do_write) begin
			if (is_pair && !is_high) begin
				next_regs.byte_latch = wd;
			end else if (is_pair) begin
				unique case (pair_base)
					rtp_pkg::IDX_COUNT_VALUE: begin
						next_count_pend = {wd, regs.byte_latch};
						next_count_sync = rtp_pkg::SYNC_SLOW_EDGES;
					end
					rtp_pkg::IDX_WRAP_LIMIT: begin
						next_regs.wrap_limit = {wd, regs.byte_latch};
						next_limit_pend = {wd, regs.byte_latch};
						next_limit_sync = rtp_pkg::SYNC_SLOW_EDGES;
					end
					default: next_regs.match_value = {wd, regs.byte_latch};
				endcase
			end else begin
				unique case (idx)
					rtp_pkg::IDX_COUNTER_CTRL: begin
						next_regs.counter_on = wd[rtp_pkg::BIT_COUNTER_ON];
						next_regs.drift_trim_on = wd[rtp_pkg::BIT_DRIFT_TRIM_ON];
						next_regs.prescale = wd[6:3];
					end
					rtp_pkg::IDX_COUNTER_FLAGS: begin
						if (wd[rtp_pkg::BIT_WRAP_FLAG]) begin
							next_flags.wrap_flag = 1'b0;
						end
						if (wd[rtp_pkg::BIT_MATCH_FLAG]) begin
							next_flags.match_flag = 1'b0;
						end
					end
					rtp_pkg::IDX_BYTE_LATCH:    next_regs.byte_latch = wd;
					rtp_pkg::IDX_HALT_BEHAVIOR:
						next_regs.run_while_halted = wd[rtp_pkg::BIT_RUN_HALTED];
					rtp_pkg::IDX_DRIFT_TRIM:    next_regs.drift_trim = wd;
					rtp_pkg::IDX_SOURCE_CHOICE: next_regs.source_choice = wd[1:0];
					rtp_pkg::IDX_TICK_SETUP: begin
						next_regs.tick_setup = {1'b0, wd[6:3], 2'h0, wd[0]};
						next_tick_sync = rtp_pkg::SYNC_SLOW_EDGES;
					end
					rtp_pkg::IDX_TICK_IRQ_EN:
						next_regs.tick_irq_en = wd[rtp_pkg::BIT_TICK_IRQ];
					rtp_pkg::IDX_TICK_IRQ_PEND: begin
						if (wd[rtp_pkg::BIT_TICK_IRQ]) begin
							next_flags.tick_irq = 1'b0;
						end
					end
					rtp_pkg::IDX_TICK_HALT:
						next_regs.tick_run_while_halted = wd[rtp_pkg::BIT_RUN_HALTED];
					default: ;
				endcase
			end
		end
		if (set_wrap) begin
			next_flags.wrap_flag = 1'b1;
		end
		if (set_match) begin
			next_flags.match_flag = 1'b1;
		end
		if (set_tick) begin
			next_flags.tick_irq = 1'b1;
		end
		next_tick_irq_out = next_flags.tick_irq && next_regs.tick_irq_en;
	end

	always_ff @(posedge clk_in) begin
		// Two-stage sampler for each slow source, third stage for the edge
		src_meta <= slow_src_in;
		src_sync <= src_meta;
		src_prev <= src_sync;
		if (!resetn_in) begin
			regs <= '{
				counter_on: 1'b0, drift_trim_on: 1'b0, prescale: 4'h0,
				run_while_halted: 1'b0, drift_trim: rtp_pkg::BYTE_RESET,
				source_choice: rtp_pkg::SRC_INTERNAL_32K,
				wrap_limit: rtp_pkg::LIMIT_RESET, match_value: rtp_pkg::MATCH_RESET,
				tick_irq_en: 1'b0, tick_run_while_halted: 1'b0,
				byte_latch: rtp_pkg::BYTE_RESET, tick_setup: rtp_pkg::BYTE_RESET};
			flags <= '0;
			avs_readdata_out <= 32'h00000000;
			avs_waitrequest_out <= 1'b1;
			tick_irq_out <= 1'b0;
			wrap_flag_out <= 1'b0;
			match_flag_out <= 1'b0;
			count_value <= rtp_pkg::COUNT_RESET;
			presc_cnt <= 16'h0000;
			trim_acc <= 20'h00000;
			ppm_cnt <= 20'h00000;
			count_sync <= 2'h0;
			count_pend <= rtp_pkg::COUNT_RESET;
			limit_sync <= 2'h0;
			limit_pend <= rtp_pkg::LIMIT_RESET;
			limit_active <= rtp_pkg::LIMIT_RESET;
			tick_sync <= 2'h0;
			tick_run <= 1'b0;
			tick_period <= rtp_pkg::TICK_PERIOD_OFF;
			tick_cnt <= 16'h0000;
		end else begin
			regs <= next_regs;
			flags <= next_flags;
			avs_readdata_out <= next_readdata;
			avs_waitrequest_out <= next_waitrequest;
			tick_irq_out <= next_tick_irq_out;
			wrap_flag_out <= next_flags.wrap_flag;
			match_flag_out <= next_flags.match_flag;
			count_value <= next_count_value;
			presc_cnt <= next_presc_cnt;
			trim_acc <= next_trim_acc;
			ppm_cnt <= next_ppm_cnt;
			count_sync <= next_count_sync;
			count_pend <= next_count_pend;
			limit_sync <= next_limit_sync;
			limit_pend <= next_limit_pend;
			limit_active <= next_limit_active;
			tick_sync <= next_tick_sync;
			tick_run <= next_tick_run;
			tick_period <= next_tick_period;
			tick_cnt <= next_tick_cnt;
		end
	end

endmodule

`default_nettype wire

// File: bench/rtp_core_asserts.sv
// Port-level assertions for the counter tail and tick timer
`timescale 1ns/1ps
`default_nettype none
module rtp_core_asserts #(
	parameter int PPM_CYCLES = rtp_pkg::PPM_INTERVAL
) (
	input wire logic        clk_in,
	input wire logic        resetn_in,
	input wire logic [7:0]  avs_address_in,
	input wire logic        avs_read_in,
	input wire logic        avs_write_in,
	input wire logic [31:0] avs_writedata_in,
	input wire logic [3:0]  avs_byteenable_in,
	input wire logic [31:0] avs_readdata_out,
	input wire logic        avs_waitrequest_out,
	input wire logic [3:0]  slow_src_in,
	input wire logic        cpu_halted_in,
	input wire logic        tick_irq_out,
	input wire logic        wrap_flag_out,
	input wire logic        match_flag_out
);
	default clocking cb @(posedge clk_in); endclocking
	default disable iff (!resetn_in);
	logic       acc_wr;
	logic [5:0] idx;
	// A write acts at the edge where waitrequest is seen low
	assign acc_wr = avs_write_in && !avs_waitrequest_out && avs_byteenable_in[0]
		&& (avs_address_in[1:0] == 2'h0);
	assign idx = avs_address_in[7:2];
	AST_ANSWER: assert property ((avs_read_in || avs_write_in) && avs_waitrequest_out
		|=> !avs_waitrequest_out) else $error("request not answered in one cycle");
	AST_ONE_CYCLE: assert property (!avs_waitrequest_out |=> avs_waitrequest_out)
		else $error("waitrequest low for more than one cycle");
	AST_NO_SPUR: assert property (!(avs_read_in || avs_write_in) && avs_waitrequest_out
		|=> avs_waitrequest_out) else $error("answer without request");
	AST_UPPER: assert property (!avs_waitrequest_out |-> avs_readdata_out[31:8] == 24'h0)
		else $error("upper read data not zero");
	AST_RD_HOLD: assert property (avs_waitrequest_out |-> $stable(avs_readdata_out))
		else $error("read data changed outside an answer");
	AST_GATE: assert property (acc_wr && idx == 6'h12 && !avs_writedata_in[0]
		|-> ##[1:2] !tick_irq_out) else $error("tick request not masked");
	AST_TICK_W1C: assert property (acc_wr && idx == 6'h13 && avs_writedata_in[0]
		|-> ##[1:2] !tick_irq_out) else $error("tick flag not cleared");
	AST_WRAP_W1C: assert property (acc_wr && idx == 6'h03 && avs_writedata_in[0]
		|-> ##[1:2] !wrap_flag_out) else $error("wrap flag not cleared");
	AST_MATCH_W1C: assert property (acc_wr && idx == 6'h03 && avs_writedata_in[1]
		|-> ##[1:2] !match_flag_out) else $error("match flag not cleared");
endmodule
bind rtp_core rtp_core_asserts #(.PPM_CYCLES(PPM_CYCLES)) u_chk (
	.clk_in(clk_in), .resetn_in(resetn_in), .avs_address_in(avs_address_in),
	.avs_read_in(avs_read_in), .avs_write_in(avs_write_in),
	.avs_writedata_in(avs_writedata_in), .avs_byteenable_in(avs_byteenable_in),
	.avs_readdata_out(avs_readdata_out), .avs_waitrequest_out(avs_waitrequest_out),
	.slow_src_in(slow_src_in), .cpu_halted_in(cpu_halted_in), .tick_irq_out(tick_irq_out),
	.wrap_flag_out(wrap_flag_out), .match_flag_out(match_flag_out)
);
`default_nettype wire

// File: bench/rtc_tail_registers_and_pit_test.sv
// Register-level testbench for the counter tail and tick timer
`timescale 1ns/1ps
`default_nettype none
module rtc_tail_registers_and_pit_test;
	logic        clk_in = 1'b0;
	logic        resetn_in = 1'b0;
	logic [7:0]  avs_address_in = 8'h00;
	logic        avs_read_in = 1'b0;
	logic        avs_write_in = 1'b0;
	logic [31:0] avs_writedata_in = 32'h0;
	logic [31:0] avs_readdata_out;
	logic        avs_waitrequest_out;
	logic [3:0]  slow_src_in = 4'h0;
	logic        cpu_halted_in = 1'b0;
	logic        tick_irq_out;
	logic        wrap_flag_out;
	logic        match_flag_out;
	logic        src3_run = 1'b0;
	wire logic [2:0] outs;
	int          n_fail = 0;
	int          comparisons = 0;
	int          cyc = 0;
	int          t_seen;
	int          t1;
	logic [7:0]  b;
	logic [15:0] v;
	logic [5:0]  ridx [9] = '{6'h04, 6'h05, 6'h06, 6'h07, 6'h10, 6'h11, 6'h12, 6'h13, 6'h0e};
	logic [5:0]  widx [5] = '{6'h05, 6'h06, 6'h07, 6'h12, 6'h15};
	logic [7:0]  wval [5] = '{8'h01, 8'h85, 8'h02, 8'h01, 8'h01};
	logic [7:0]  quiet [3] = '{8'h01, 8'h79, 8'h08};
	logic [1:0]  tsrc [5] = '{2'h0, 2'h0, 2'h0, 2'h1, 2'h3};
	logic [3:0]  tcode [5] = '{4'h1, 4'h2, 4'h3, 4'h1, 4'h1};
	logic [15:0] tgap [5] = '{16'h0020, 16'h0040, 16'h0080, 16'h0040, 16'h0010};
	logic [7:0]  dctl [3] = '{8'h09, 8'h0d, 8'h0d};
	logic [7:0]  dtrim [3] = '{8'h20, 8'h20, 8'ha0};
	logic [15:0] dlo [3] = '{16'h003e, 16'h001e, 16'h005e};
	assign outs = {match_flag_out, wrap_flag_out, tick_irq_out};
	always #5 clk_in = ~clk_in;
	// Source 0 and 2 run at 8 clocks, source 1 at 16, source 3 only on demand
	always @(posedge clk_in) begin
		cyc <= cyc + 1;
		slow_src_in <= {src3_run & cyc[1], cyc[2], cyc[3], cyc[2]};
		if (cyc == 60000) begin
			n_fail++;
			end_sim();
		end
	end
	rtp_core #(.PPM_CYCLES(64)) u_dut (
		.clk_in(clk_in), .resetn_in(resetn_in), .avs_address_in(avs_address_in),
		.avs_read_in(avs_read_in), .avs_write_in(avs_write_in),
		.avs_writedata_in(avs_writedata_in), .avs_byteenable_in(4'h1),
		.avs_readdata_out(avs_readdata_out), .avs_waitrequest_out(avs_waitrequest_out),
		.slow_src_in(slow_src_in), .cpu_halted_in(cpu_halted_in), .tick_irq_out(tick_irq_out),
		.wrap_flag_out(wrap_flag_out), .match_flag_out(match_flag_out)
	);
	task end_sim;
		$display("Counts: %0d mismatches in %0d comparisons", n_fail, comparisons);
		if (n_fail == 0 && comparisons > 0)
			$display("TEST PASSED");
		else
			$display("TEST FAILED");
		$finish;
	endtask
	task chk(input string nm, input logic [15:0] seen, input logic [15:0] exp);
		comparisons++;
		if (seen !== exp) begin
			n_fail++;
			$display("Error %s expected %h seen %h", nm, exp, seen);
		end
	endtask
	// Entered just after a rising edge; held until the edge that sees waitrequest low
	task bus(input logic wr, input logic [5:0] idx, input logic [7:0] d, output logic [7:0] q);
		avs_address_in <= {idx, 2'h0};
		avs_writedata_in <= {24'h0, d};
		avs_write_in <= wr;
		avs_read_in <= !wr;
		do
			@(posedge clk_in);
		while (avs_waitrequest_out !== 1'b0);
		q = avs_readdata_out[7:0];
		avs_write_in <= 1'b0;
		avs_read_in <= 1'b0;
		// Idle edge so the next call never re-raises in this time step
		@(posedge clk_in);
	endtask
	task wr8(input logic [5:0] idx, input logic [7:0] d);
		logic [7:0] q;
		bus(1'b1, idx, d, q);
	endtask
	task rd8(input logic [5:0] idx, output logic [7:0] q);
		bus(1'b0, idx, 8'h00, q);
	endtask
	task rd16(input logic [5:0] idx, output logic [15:0] q);
		logic [7:0] lo;
		logic [7:0] hi;
		rd8(idx, lo);
		rd8(idx + 6'h01, hi);
		q = {hi, lo};
	endtask
	task wr16(input logic [5:0] idx, input logic [15:0] d);
		wr8(idx, d[7:0]);
		wr8(idx + 6'h01, d[15:8]);
	endtask
	task wait_out(input int sel);
		int n;
		n = 0;
		do begin
			@(negedge clk_in);
			n++;
		end while (outs[sel] !== 1'b1 && n < 2000);
		t_seen = cyc;
		@(posedge clk_in);
		chk("flag output", outs[sel], 1'b1);
	endtask
	task wait_sync(input logic [5:0] idx, input int bt);
		logic [7:0] q;
		int n;
		n = 0;
		rd8(idx, q);
		chk("sync busy", q[bt], 1'b1);
		do begin
			rd8(idx, q);
			n++;
		end while (q[bt] !== 1'b0 && n < 50);
		chk("sync done", q[bt], 1'b0);
	endtask
	task setup_tick(input logic [7:0] d);
		wr8(6'h10, d);
		wait_sync(6'h11, 0);
		wr8(6'h13, 8'h01);
	endtask
	initial begin
		repeat (3) @(posedge clk_in);
		resetn_in <= 1'b1;
		@(posedge clk_in);
		wr8(6'h0e, 8'hff);
		foreach (ridx[i]) begin
			rd8(ridx[i], b);
			chk("reset byte", b, 16'h0000);
		end
		rd16(6'h08, v);
		chk("count reset", v, 16'h0000);
		rd16(6'h0a, v);
		chk("limit reset", v, 16'hffff);
		rd16(6'h0c, v);
		chk("match reset", v, 16'h0000);
		foreach (widx[i]) begin
			wr8(widx[i], wval[i]);
			rd8(widx[i], b);
			chk("reg rw", b, wval[i]);
			wr8(widx[i], 8'h00);
		end
		wr16(6'h0c, 16'h1234);
		rd16(6'h0c, v);
		chk("match", v, 16'h1234);
		rd8(6'h04, b);
		chk("latch after read", b, 8'h12);
		wr8(6'h04, 8'h5a);
		wr8(6'h0d, 8'h77);
		rd16(6'h0c, v);
		chk("latch commit", v, 16'h775a);
		wr16(6'h08, 16'h1234);
		wait_sync(6'h01, 1);
		rd16(6'h08, v);
		chk("count", v, 16'h1234);
		wr16(6'h08, 16'h0000);
		wait_sync(6'h01, 1);
		rd8(6'h01, b);
		chk("limit sync idle", b[2], 1'b0);
		wr16(6'h0a, 16'h0003);
		rd16(6'h0a, v);
		chk("limit", v, 16'h0003);
		wait_sync(6'h01, 2);
		wr16(6'h0c, 16'h0002);
		wr8(6'h00, 8'h01);
		wait_out(1);
		wait_out(2);
		wr8(6'h07, 8'h03);
		wr8(6'h03, 8'h03);
		repeat (100) @(posedge clk_in);
		chk("stopped source flags", outs[2:1], 2'h0);
		wr8(6'h07, 8'h00);
		wait_out(1);
		cpu_halted_in <= 1'b1;
		wr8(6'h03, 8'h03);
		repeat (200) @(posedge clk_in);
		chk("frozen counter", outs[2:1], 2'h0);
		wr8(6'h05, 8'h01);
		wait_out(1);
		cpu_halted_in <= 1'b0;
		rd8(6'h01, b);
		chk("limit sync idle", b[2], 1'b0);
		wr16(6'h0a, 16'hffff);
		wait_sync(6'h01, 2);
		// Trim stored but off, then slowing, then speeding; prescale kept at two
		foreach (dctl[i]) begin
			wr8(6'h00, 8'h00);
			wr8(6'h06, dtrim[i]);
			wr16(6'h08, 16'h0000);
			wait_sync(6'h01, 1);
			wr8(6'h00, dctl[i]);
			repeat (1024) @(posedge clk_in);
			rd16(6'h08, v);
			chk("trimmed count", v - dlo[i] <= 16'h0004, 1'b1);
		end
		wr8(6'h00, 8'h00);
		wr8(6'h03, 8'h03);
		wr8(6'h12, 8'h01);
		src3_run <= 1'b1;
		// Gap in clocks tells the selected source apart as well as the period
		foreach (tcode[i]) begin
			wr8(6'h07, {6'h00, tsrc[i]});
			setup_tick({1'b0, tcode[i], 3'h1});
			wait_out(0);
			t1 = t_seen;
			wr8(6'h13, 8'h01);
			wait_out(0);
			chk("tick gap", 16'(t_seen - t1), tgap[i]);
		end
		wr8(6'h12, 8'h00);
		rd8(6'h13, b);
		chk("masked request", {b[0], tick_irq_out}, 2'h2);
		foreach (quiet[i]) begin
			setup_tick(quiet[i]);
			repeat (300) @(posedge clk_in);
			rd8(6'h13, b);
			chk("no tick", b, 8'h00);
		end
		wr8(6'h12, 8'h01);
		cpu_halted_in <= 1'b1;
		setup_tick(8'h09);
		repeat (300) @(posedge clk_in);
		rd8(6'h13, b);
		chk("frozen tick", b, 8'h00);
		wr8(6'h15, 8'h01);
		wait_out(0);
		end_sim();
	end
endmodule
`default_nettype wire
